/* File: rtl/fault_monitor_pkg.sv */
// shared constants, register map and state types of the fault monitor
package fault_monitor_pkg;
   localparam int CLK_MHZ = 125;
   // debounce windows in their own units
   localparam int T_ILIM_US     = 20;
   localparam int T_THERM_US    = 20;
   localparam int T_OVERLOAD_MS = 1;
   localparam int T_SYNC_US     = 3;
   localparam int T_OVP_RISE_US = 1;
   localparam int T_OVP_FALL_US = 20;
   localparam int T_PG_US       = 6;
   localparam int CYC_ILIM      = T_ILIM_US * CLK_MHZ;
   localparam int CYC_THERM     = T_THERM_US * CLK_MHZ;
   localparam int CYC_OVERLOAD  = T_OVERLOAD_MS * 1000 * CLK_MHZ;
   localparam int CYC_SYNC      = T_SYNC_US * CLK_MHZ;
   localparam int CYC_OVP_RISE  = T_OVP_RISE_US * CLK_MHZ;
   localparam int CYC_OVP_FALL  = T_OVP_FALL_US * CLK_MHZ;
   localparam int CYC_PG        = T_PG_US * CLK_MHZ;
   localparam int CNT_W         = 17;
   // register byte offsets
   localparam logic [7:0] OFS_FLAGS  = 8'h00;
   localparam logic [7:0] OFS_MASK   = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CTRL   = 8'h0c;
   localparam logic [7:0] OFS_GPO    = 8'h10;
   // field positions (regulators ordered buck0, buck1, linear0, linear1)
   localparam int FLG_SHORT_LSB = 4;
   localparam int FLG_HOT       = 8;
   localparam int FLG_TSD       = 9;
   localparam int FLG_OVP       = 10;
   localparam int FLG_RST       = 11;
   localparam int FLG_SUM_LSB   = 12;
   localparam int STA_RUN_LSB   = 4;
   localparam int STA_STATE_LSB = 12;
   localparam int CTL_DIS_LSB   = 4;
   localparam int CTL_HOT_SEL   = 8;
   localparam int CTL_PIN_SEL   = 9;
   localparam int CTL_SOFTWARE_RESET_REQUEST  = 10;
   localparam int CTL_PIN_LSB   = 12;
   localparam int GPO_LVL_LSB   = 2;
   localparam int GPO_SEQ_LSB   = 4;
   // reset values
   localparam logic RST_MASK_DEFAULT = 1'b0;

   typedef enum logic [1:0] {OP_SHUTDOWN, OP_STANDBY, OP_ACTIVE} op_state_t;

   typedef struct packed {
      logic [2:0]       sync;
      logic             out;
      logic [CNT_W-1:0] cnt;
   } filt_state_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic [3:0]  ovc_flag;
      logic [3:0]  short_flag;
      logic        hot_flag;
      logic        tsd_flag;
      logic        ovp_flag;
      logic        rst_flag;
      logic [3:0]  ovc_mask;
      logic        hot_mask;
      logic        rst_mask;
      logic [3:0]  ovc_live;
      logic        hot_live;
      logic [3:0]  run;
      logic [3:0]  want;
      logic [3:0]  pin_ctrl;
      logic [3:0]  dis_en;
      logic        hot_sel;
      logic        pin_sel;
      logic [1:0]  gpo_od;
      logic [1:0]  gpo_lvl;
      logic [1:0]  gpo_seq;
      logic [1:0]  gpo_out;
      logic        software_reset_request;
      logic        irq_n;
      op_state_t   state;
   } mon_state_t;

   localparam mon_state_t MON_RESET = '{irq_n: 1'b1, state: OP_SHUTDOWN, default: '0};
endpackage

/* File: rtl/pmic_fault_monitor_irq.sv */
// fault supervision, debounce filters, general outputs and interrupt of the power monitor
// Overview of operation
// - current limit held 20 us sets flag
// - live current-limit status; write one clears flag
// - mask bit one blocks current-limit, warning interrupt
// - hot warning sets flag; threshold select, live
// - disabled regulator: switches off, optional discharge
// - output low 1 ms after enable disables
// - output low 1 ms in operation disables
// - short disable sets flags, clears running status
// - clearing short flag restarts enabled regulator
// - overvoltage kills regulators, outputs low, flag set
// - overvoltage checked only in standby or active
// - overvoltage clear ignored while present; live bit
// - overvoltage live or pending blocks enabling
// - overheat kills regulators, flag, enter standby
// - overheat clear ignored while present; live bit; blocks enabling
// - undervoltage shuts down, discharges, returns to standby
// - shutdown or soft reset restores defaults, flag
// - shared pin selects second output or clock
// - outputs have drive type, level, sequencing
// - inputs debounced by clock and counter
// - enable and supply release synchronised 3 us
// - overvoltage filtered 1 us up, 20 us down
// - power good filtered 6 us both ways
`timescale 1ns/1ps

module sig_debounce
   import fault_monitor_pkg::*;
#(
   parameter logic [CNT_W-1:0] RISE_CYC = '0,
   parameter logic [CNT_W-1:0] FALL_CYC = '0
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   filt_state_t      st_ff;
   filt_state_t      nxt_st;
   logic [CNT_W-1:0] lim;

   // window depends on the direction of the pending change
   assign lim = st_ff.out ? FALL_CYC : RISE_CYC;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.sync = {st_ff.sync[1:0], din};
      nxt_st.cnt  = '0;
      // a change only counts once the second and third stages agree
      if (st_ff.sync[2] == st_ff.sync[1] && st_ff.sync[2] != st_ff.out) begin
         if (lim == '0 || st_ff.cnt == lim - 1'b1) begin
            nxt_st.out = st_ff.sync[2];
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.out;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_filter_window: assert property ($changed(st_ff.out) |->
      ($past(lim) == '0 || $past(st_ff.cnt) == $past(lim) - 1'b1))
      else $error("filter output changed before its window ran out");
endmodule

module pmic_fault_monitor_irq
   import fault_monitor_pkg::*;
#(
   parameter int OVERLOAD_CYCLES = CYC_OVERLOAD
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [3:0]  reg_ilim_cmp,
   input  wire logic [3:0]  reg_out_low_cmp,
   input  wire logic [3:0]  reg_pg_cmp,
   input  wire logic        hot_warning_cmp,
   input  wire logic        overheat_cmp,
   input  wire logic        supply_ov_cmp,
   input  wire logic        main_supply_ok_cmp,
   input  wire logic        enable_pin,
   output logic [3:0]       reg_run,
   output logic [3:0]       reg_switch_hiz,
   output logic [3:0]       reg_discharge_on,
   output logic [3:0]       power_good_filtered,
   output logic             hot_warning_threshold_sel,
   output logic             shared_pin_function_sel,
   output logic             general_output_one_o,
   output logic             general_output_one_oe,
   output logic             general_output_two_o,
   output logic             general_output_two_oe,
   output logic             irq_out_n
);
   mon_state_t  st_ff;
   mon_state_t  nxt_st;
   logic [3:0]  ilim_f;
   logic [3:0]  low_f;
   logic [3:0]  low_raw;
   logic        hot_f;
   logic        tsd_f;
   logic        ovp_f;
   logic        sup_f;
   logic        en_f;
   logic        ovp_live;
   logic        block_en;
   logic [3:0]  want_eff;
   logic [3:0]  short_set;
   logic        req;
   logic        wr;
   logic [15:0] wmask;
   logic [15:0] wr_clr;
   logic [15:0] rd_flags;
   logic [15:0] rd_mask;
   logic [15:0] rd_status;
   logic [15:0] rd_ctrl;
   logic [15:0] rd_gpo;
   logic [15:0] mg_mask;
   logic [15:0] mg_ctrl;
   logic [15:0] mg_gpo;
   logic [1:0]  gpo_lvl_eff;

   // per-regulator filters
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_reg
         // counting starts only while running, so start-up and overload share one timer
         assign low_raw[gi] = reg_out_low_cmp[gi] & st_ff.run[gi];
         sig_debounce #(.RISE_CYC(CNT_W'(CYC_ILIM)), .FALL_CYC(CNT_W'(CYC_ILIM)))
            u_ilim (.sys_clk(sys_clk), .rst_n(rst_n), .din(reg_ilim_cmp[gi]),
                    .dout(ilim_f[gi]));
         sig_debounce #(.RISE_CYC(CNT_W'(OVERLOAD_CYCLES)), .FALL_CYC('0))
            u_low (.sys_clk(sys_clk), .rst_n(rst_n), .din(low_raw[gi]),
                   .dout(low_f[gi]));
         sig_debounce #(.RISE_CYC(CNT_W'(CYC_PG)), .FALL_CYC(CNT_W'(CYC_PG)))
            u_pg (.sys_clk(sys_clk), .rst_n(rst_n), .din(reg_pg_cmp[gi]),
                  .dout(power_good_filtered[gi]));
      end
   endgenerate

   sig_debounce #(.RISE_CYC(CNT_W'(CYC_THERM)), .FALL_CYC(CNT_W'(CYC_THERM)))
      u_hot (.sys_clk(sys_clk), .rst_n(rst_n), .din(hot_warning_cmp), .dout(hot_f));
   sig_debounce #(.RISE_CYC(CNT_W'(CYC_THERM)), .FALL_CYC(CNT_W'(CYC_THERM)))
      u_tsd (.sys_clk(sys_clk), .rst_n(rst_n), .din(overheat_cmp), .dout(tsd_f));
   sig_debounce #(.RISE_CYC(CNT_W'(CYC_OVP_RISE)), .FALL_CYC(CNT_W'(CYC_OVP_FALL)))
      u_ovp (.sys_clk(sys_clk), .rst_n(rst_n), .din(supply_ov_cmp),
             .dout(ovp_f));
   // a falling supply acts as soon as the synchroniser agrees
   sig_debounce #(.RISE_CYC(CNT_W'(CYC_SYNC)), .FALL_CYC('0))
      u_sup (.sys_clk(sys_clk), .rst_n(rst_n), .din(main_supply_ok_cmp),
             .dout(sup_f));
   sig_debounce #(.RISE_CYC(CNT_W'(CYC_SYNC)), .FALL_CYC(CNT_W'(CYC_SYNC)))
      u_en (.sys_clk(sys_clk), .rst_n(rst_n), .din(enable_pin), .dout(en_f));

   assign ovp_live = ovp_f & (st_ff.state != OP_SHUTDOWN);
   assign block_en = ovp_live | st_ff.ovp_flag | tsd_f | st_ff.tsd_flag | ~sup_f;
   assign want_eff = st_ff.want & ~(st_ff.pin_ctrl & {4{~en_f}});
   assign short_set = low_f & st_ff.run;

   // bus decode: ack one cycle after the request, write at the edge that sees ack
   assign req   = wb_cyc_i & wb_stb_i;
   assign wr    = req & wb_we_i & st_ff.ack;
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_clr = (wr && wb_adr_i == OFS_FLAGS) ? (wb_dat_i[15:0] & wmask) : '0;

   always_comb begin
      rd_flags = '0;
      rd_flags[3:0] = st_ff.ovc_flag;
      rd_flags[FLG_SHORT_LSB +: 4] = st_ff.short_flag;
      rd_flags[FLG_HOT] = st_ff.hot_flag;
      rd_flags[FLG_TSD] = st_ff.tsd_flag;
      rd_flags[FLG_OVP] = st_ff.ovp_flag;
      rd_flags[FLG_RST] = st_ff.rst_flag;
      rd_flags[FLG_SUM_LSB +: 4] = st_ff.short_flag | st_ff.ovc_flag;
      rd_mask = '0;
      rd_mask[3:0] = st_ff.ovc_mask;
      rd_mask[FLG_HOT] = st_ff.hot_mask;
      rd_mask[FLG_RST] = st_ff.rst_mask;
      rd_status = '0;
      rd_status[3:0] = st_ff.ovc_live;
      rd_status[STA_RUN_LSB +: 4] = st_ff.run;
      rd_status[FLG_HOT] = st_ff.hot_live;
      rd_status[FLG_TSD] = tsd_f;
      rd_status[FLG_OVP] = ovp_live;
      rd_status[STA_STATE_LSB +: 2] = st_ff.state;
      rd_ctrl = '0;
      rd_ctrl[3:0] = st_ff.want;
      rd_ctrl[CTL_DIS_LSB +: 4] = st_ff.dis_en;
      rd_ctrl[CTL_HOT_SEL] = st_ff.hot_sel;
      rd_ctrl[CTL_PIN_SEL] = st_ff.pin_sel;
      rd_ctrl[CTL_PIN_LSB +: 4] = st_ff.pin_ctrl;
      rd_gpo = '0;
      rd_gpo[1:0] = st_ff.gpo_od;
      rd_gpo[GPO_LVL_LSB +: 2] = st_ff.gpo_lvl;
      rd_gpo[GPO_SEQ_LSB +: 2] = st_ff.gpo_seq;
   end

   assign mg_mask = (rd_mask & ~wmask) | (wb_dat_i[15:0] & wmask);
   assign mg_ctrl = (rd_ctrl & ~wmask) | (wb_dat_i[15:0] & wmask);
   assign mg_gpo  = (rd_gpo & ~wmask) | (wb_dat_i[15:0] & wmask);

   // sequenced outputs follow the enable pin; overvoltage forces both low
   assign gpo_lvl_eff = (st_ff.gpo_lvl & ~(st_ff.gpo_seq & {2{~en_f}}))
                        & {2{~(ovp_live | st_ff.ovp_flag)}};

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.ack   = req & ~st_ff.ack;
      nxt_st.rdata = st_ff.rdata;
      if (req && !st_ff.ack) begin
         unique case (wb_adr_i)
            OFS_FLAGS:  nxt_st.rdata = {16'h0000, rd_flags};
            OFS_MASK:   nxt_st.rdata = {16'h0000, rd_mask};
            OFS_STATUS: nxt_st.rdata = {16'h0000, rd_status};
            OFS_CTRL:   nxt_st.rdata = {16'h0000, rd_ctrl};
            OFS_GPO:    nxt_st.rdata = {16'h0000, rd_gpo};
            default:    nxt_st.rdata = 32'h0000_0000;
         endcase
      end
      nxt_st.software_reset_request = 1'b0;
      if (wr && wb_adr_i == OFS_MASK) begin
         nxt_st.ovc_mask = mg_mask[3:0];
         nxt_st.hot_mask = mg_mask[FLG_HOT];
         nxt_st.rst_mask = mg_mask[FLG_RST];
      end
      if (wr && wb_adr_i == OFS_CTRL) begin
         nxt_st.want     = mg_ctrl[3:0];
         nxt_st.dis_en   = mg_ctrl[CTL_DIS_LSB +: 4];
         nxt_st.hot_sel  = mg_ctrl[CTL_HOT_SEL];
         nxt_st.pin_sel  = mg_ctrl[CTL_PIN_SEL];
         nxt_st.pin_ctrl = mg_ctrl[CTL_PIN_LSB +: 4];
         nxt_st.software_reset_request = wb_dat_i[CTL_SOFTWARE_RESET_REQUEST] & wb_sel_i[1];
      end
      if (wr && wb_adr_i == OFS_GPO) begin
         nxt_st.gpo_od  = mg_gpo[1:0];
         nxt_st.gpo_lvl = mg_gpo[GPO_LVL_LSB +: 2];
         nxt_st.gpo_seq = mg_gpo[GPO_SEQ_LSB +: 2];
      end
      // sticky flags: a set in the clearing cycle wins
      nxt_st.ovc_live = ilim_f;
      nxt_st.ovc_flag = (st_ff.ovc_flag & ~wr_clr[3:0])
                      | (ilim_f & ~st_ff.ovc_live);
      nxt_st.hot_live = hot_f;
      nxt_st.hot_flag = (st_ff.hot_flag & ~wr_clr[FLG_HOT])
                      | (hot_f & ~st_ff.hot_live);
      nxt_st.short_flag = (st_ff.short_flag & ~wr_clr[FLG_SHORT_LSB +: 4])
                        | short_set;
      // overvoltage and overheat are level-set: a clear cannot stick while the condition is present; reset flag clears
      nxt_st.ovp_flag = (st_ff.ovp_flag & ~wr_clr[FLG_OVP]) | ovp_live;
      nxt_st.tsd_flag = (st_ff.tsd_flag & ~wr_clr[FLG_TSD]) | tsd_f;
      nxt_st.rst_flag = st_ff.rst_flag & ~wr_clr[FLG_RST];
      // restart follows once the short flag is gone and nothing else blocks
      nxt_st.run = want_eff & ~{4{block_en}} & ~st_ff.short_flag & ~short_set;
      nxt_st.gpo_out = gpo_lvl_eff;
      // supply loss or soft reset restores every programmable field
      if (!sup_f || st_ff.software_reset_request) begin
         nxt_st.ovc_flag   = '0;
         nxt_st.short_flag = '0;
         nxt_st.hot_flag   = 1'b0;
         nxt_st.tsd_flag   = 1'b0;
         nxt_st.ovp_flag   = 1'b0;
         nxt_st.ovc_mask   = '0;
         nxt_st.hot_mask   = 1'b0;
         nxt_st.rst_mask   = RST_MASK_DEFAULT;
         nxt_st.rst_flag   = ~RST_MASK_DEFAULT;
         nxt_st.want       = '0;
         nxt_st.pin_ctrl   = '0;
         nxt_st.dis_en     = '0;
         nxt_st.hot_sel    = 1'b0;
         nxt_st.pin_sel    = 1'b0;
         nxt_st.gpo_od     = '0;
         nxt_st.gpo_lvl    = '0;
         nxt_st.gpo_seq    = '0;
         nxt_st.gpo_out    = '0;
         nxt_st.run        = '0;
      end
      unique case (st_ff.state)
         OP_SHUTDOWN: nxt_st.state = sup_f ? OP_STANDBY : OP_SHUTDOWN;
         OP_STANDBY,
         OP_ACTIVE:   nxt_st.state = !sup_f ? OP_SHUTDOWN
                                    : (|nxt_st.run ? OP_ACTIVE : OP_STANDBY);
      endcase
      nxt_st.irq_n = ~(|(nxt_st.ovc_flag & ~nxt_st.ovc_mask)
                     | (nxt_st.hot_flag & ~nxt_st.hot_mask)
                     | (|nxt_st.short_flag) | nxt_st.tsd_flag | nxt_st.ovp_flag
                     | (nxt_st.rst_flag & ~nxt_st.rst_mask));
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= MON_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_ack_o  = st_ff.ack;
   assign wb_dat_o  = st_ff.rdata;
   assign reg_run   = st_ff.run;
   assign irq_out_n = st_ff.irq_n;
   assign reg_switch_hiz = ~st_ff.run;
   // discharge only where software allowed it, always while the supply is gone
   assign reg_discharge_on = ~st_ff.run
                             & (st_ff.dis_en | {4{st_ff.state == OP_SHUTDOWN}});
   assign hot_warning_threshold_sel = st_ff.hot_sel;
   assign shared_pin_function_sel   = st_ff.pin_sel;
   // open drain only ever pulls low, push-pull drives both levels
   assign general_output_one_o  = st_ff.gpo_out[0] & ~st_ff.gpo_od[0];
   assign general_output_one_oe = ~st_ff.gpo_od[0] | ~st_ff.gpo_out[0];
   assign general_output_two_o  = st_ff.gpo_out[1] & ~st_ff.gpo_od[1];
   assign general_output_two_oe = ~st_ff.pin_sel
                                  & (~st_ff.gpo_od[1] | ~st_ff.gpo_out[1]);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_short_cleared;
      $fell(st_ff.short_flag[0]) && want_eff[0] && !block_en && !low_f[0];
   endsequence

   chk_ilim_sets_flag: assert property ($rose(st_ff.ovc_live[2])
      |-> st_ff.ovc_flag[2])
      else $error("current limit did not latch its flag");
   chk_mask_gates_irq: assert property (st_ff.ovc_flag[2] && !st_ff.ovc_mask[2]
      |-> !irq_out_n)
      else $error("unmasked current-limit flag left interrupt high");
   chk_hot_warn_flag: assert property ($rose(st_ff.hot_live) |-> st_ff.hot_flag)
      else $error("hot warning not latched");
   chk_short_disables: assert property ($rose(st_ff.short_flag[0])
      |-> !st_ff.run[0] && !irq_out_n)
      else $error("short fault left regulator running");
   chk_short_restart: assert property (s_short_cleared |=> st_ff.run[0])
      else $error("regulator did not restart after clear");
   chk_ovp_kills_all: assert property (ovp_live |=> st_ff.run == 4'h0 && st_ff.gpo_out == 2'b00
      && st_ff.ovp_flag)
      else $error("overvoltage response missing");
   chk_ovp_clear_held: assert property ($past(ovp_live) |-> st_ff.ovp_flag)
      else $error("overvoltage flag cleared while present");
   chk_block_enable: assert property (st_ff.ovp_flag || st_ff.tsd_flag
      |-> st_ff.run == 4'h0)
      else $error("regulator enabled while fault pending");
   chk_tsd_standby: assert property (tsd_f && sup_f && st_ff.state != OP_SHUTDOWN
      |=> ##1 st_ff.state == OP_STANDBY)
      else $error("overheat did not leave active state");
   chk_uvlo_shutdown: assert property (!sup_f |=> st_ff.state == OP_SHUTDOWN && st_ff.run == 4'h0
      && st_ff.rst_flag)
      else $error("supply loss not handled");
   chk_soft_reset: assert property (st_ff.software_reset_request
      |=> st_ff.rst_flag == ~RST_MASK_DEFAULT && st_ff.want == 4'h0 && st_ff.run == 4'h0)
      else $error("soft reset did not restore defaults");
   chk_pin_gates_run: assert property ($fell(en_f)
      |=> (st_ff.run & st_ff.pin_ctrl) == 4'h0)
      else $error("enable pin low left a sequenced regulator running");
   chk_shared_pin_off: assert property (st_ff.pin_sel |-> !general_output_two_oe)
      else $error("second output drove the shared clock pin");
   chk_ovp_when_off: assert property (st_ff.state == OP_SHUTDOWN
      && !st_ff.ovp_flag |=> !st_ff.ovp_flag)
      else $error("overvoltage latched while shut down");
   chk_short_holds_irq: assert property (|st_ff.short_flag |-> !irq_out_n)
      else $error("pending short flag left interrupt high");
endmodule

/* File: test/reg_plant_model.sv */
// regulator output model that drives the comparators the monitor watches
`timescale 1ns/1ps
module reg_plant_model #(
   parameter int RAMP = 20
) (
   input  wire logic       sys_clk,
   input  wire logic [3:0] reg_run,
   input  wire logic [3:0] short_cmd,
   output logic [3:0]      reg_out_low_cmp,
   output logic [3:0]      reg_pg_cmp
);
   int ramp_ff [4];
   // output sits below threshold while ramping, so every start-up shows low first
   always @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (!reg_run[i]) begin
            ramp_ff[i] <= 0;
         end else if (ramp_ff[i] < RAMP) begin
            ramp_ff[i] <= ramp_ff[i] + 1;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         reg_out_low_cmp[i] = short_cmd[i] | (ramp_ff[i] < RAMP);
         reg_pg_cmp[i]      = reg_run[i] & ~reg_out_low_cmp[i];
      end
   end
endmodule

/* File: test/pmic_fault_monitor_irq_bench.sv */
// self-checking bench of the fault monitor, driven over wishbone
`timescale 1ns/1ps
module pmic_fault_monitor_irq_bench;
   import fault_monitor_pkg::*;
   logic        sys_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack_o, hot_sel, pin_sel;
   logic        g1o, g1oe, g2o, g2oe, irq_out_n, hot_cmp, ovh_cmp, ov_cmp, sup_ok, en_pin;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel, ilim, out_low, pg, short_cmd, reg_run, hiz, dis_on, pg_f;
   logic [31:0] wb_dat, wb_dat_o;
   int          n_mismatch, checks;

   pmic_fault_monitor_irq #(.OVERLOAD_CYCLES(50)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .reg_ilim_cmp(ilim), .reg_out_low_cmp(out_low), .reg_pg_cmp(pg),
      .hot_warning_cmp(hot_cmp), .overheat_cmp(ovh_cmp), .supply_ov_cmp(ov_cmp),
      .main_supply_ok_cmp(sup_ok), .enable_pin(en_pin), .reg_run(reg_run),
      .reg_switch_hiz(hiz), .reg_discharge_on(dis_on), .power_good_filtered(pg_f),
      .hot_warning_threshold_sel(hot_sel), .shared_pin_function_sel(pin_sel),
      .general_output_one_o(g1o), .general_output_one_oe(g1oe),
      .general_output_two_o(g2o), .general_output_two_oe(g2oe), .irq_out_n(irq_out_n));
   reg_plant_model PLANT (.sys_clk(sys_clk), .reg_run(reg_run), .short_cmd(short_cmd),
      .reg_out_low_cmp(out_low), .reg_pg_cmp(pg));

   always #4 sys_clk = ~sys_clk;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // request held until ack is sampled high; the next call leaves one idle cycle
   task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= a;
      wb_dat <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      ck("ack wait", n, 32'd2);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      logic [31:0] q;
      xfer(a, 1'b0, 32'h0, q);
      ck(nm, q & m, e);
   endtask
   task automatic done(input string nm);
      $display("test %s done, mismatches %0d", nm, n_mismatch);
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      sys_clk = 0; rst_n = 0; wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = 8'h00;
      wb_sel = 4'h3; wb_dat = 32'h0; ilim = 4'h0; short_cmd = 4'h0; hot_cmp = 0;
      ovh_cmp = 0; ov_cmp = 0; sup_ok = 1; n_mismatch = 0; checks = 0; en_pin = 1;
      w(10);
      rst_n <= 1'b1;
      w(400);
      rc("rst flag", OFS_FLAGS, 32'h800, 32'h800);
      ck("irq", irq_out_n, 0);
      rc("state", OFS_STATUS, 32'h3000, 32'h1000);
      wr(OFS_FLAGS, 32'h800);
      w(3);
      ck("irq", irq_out_n, 1);
      rc("unmapped", 8'h20, 32'hffffffff, 32'h0);
      rc("mask", OFS_MASK, 32'hffffffff, 32'h0);
      done("reset");
      ilim <= 4'h4;
      w(2400);
      ck("irq early", irq_out_n, 1);
      w(200);
      ck("irq", irq_out_n, 0);
      rc("ovc flag", OFS_FLAGS, 32'hf, 32'h4);
      rc("ovc live", OFS_STATUS, 32'hf, 32'h4);
      ilim <= 4'h0;
      w(2600);
      rc("ovc live", OFS_STATUS, 32'hf, 32'h0);
      rc("ovc sticky", OFS_FLAGS, 32'hf, 32'h4);
      wr(OFS_FLAGS, 32'h4);
      rc("ovc clr", OFS_FLAGS, 32'hf, 32'h0);
      wr(OFS_MASK, 32'h4);
      ilim <= 4'h4;
      w(2600);
      ck("irq masked", irq_out_n, 1);
      rc("ovc flag", OFS_FLAGS, 32'hf, 32'h4);
      ilim <= 4'h0;
      wr(OFS_FLAGS, 32'h4);
      wr(OFS_MASK, 32'h0);
      done("current limit");
      wr(OFS_CTRL, 32'h100);
      w(2);
      ck("hot sel", hot_sel, 1);
      hot_cmp <= 1'b1;
      w(2600);
      ck("irq", irq_out_n, 0);
      rc("hot", OFS_FLAGS, 32'h100, 32'h100);
      rc("hot live", OFS_STATUS, 32'h100, 32'h100);
      wr(OFS_MASK, 32'h100);
      w(3);
      ck("irq masked", irq_out_n, 1);
      hot_cmp <= 1'b0;
      wr(OFS_FLAGS, 32'h100);
      wr(OFS_MASK, 32'h0);
      done("hot warning");
      wr(OFS_GPO, 32'hc);
      wr(OFS_CTRL, 32'h11);
      w(100);
      ck("run", reg_run, 4'h1);
      rc("state", OFS_STATUS, 32'h30f0, 32'h2010);
      w(500);
      ck("pg early", pg_f, 4'h0);
      w(200);
      ck("pg", pg_f, 4'h1);
      ck("gpo", {g1o, g1oe, g2o, g2oe}, 4'hf);
      short_cmd <= 4'h1;
      w(100);
      ck("run", reg_run, 4'h0);
      ck("hiz", hiz, 4'hf);
      ck("dis", dis_on, 4'h1);
      ck("irq", irq_out_n, 0);
      rc("short", OFS_FLAGS, 32'h1010, 32'h1010);
      rc("running", OFS_STATUS, 32'h10, 32'h0);
      short_cmd <= 4'h0;
      wr(OFS_FLAGS, 32'h10);
      w(3);
      ck("restart", reg_run, 4'h1);
      done("short");
      ov_cmp <= 1'b1;
      w(200);
      ck("run", reg_run, 4'h0);
      ck("gpo low", {g1o, g2o}, 2'b00);
      ck("irq", irq_out_n, 0);
      wr(OFS_FLAGS, 32'h400);
      rc("ovp kept", OFS_FLAGS, 32'h400, 32'h400);
      rc("ovp live", OFS_STATUS, 32'h400, 32'h400);
      ov_cmp <= 1'b0;
      w(2600);
      ck("blocked", reg_run, 4'h0);
      wr(OFS_FLAGS, 32'h400);
      w(3);
      ck("run", reg_run, 4'h1);
      done("overvoltage");
      ovh_cmp <= 1'b1;
      w(2600);
      ck("run", reg_run, 4'h0);
      rc("tsd", OFS_STATUS, 32'h3200, 32'h1200);
      wr(OFS_FLAGS, 32'h200);
      rc("tsd kept", OFS_FLAGS, 32'h200, 32'h200);
      ovh_cmp <= 1'b0;
      w(2600);
      ck("blocked", reg_run, 4'h0);
      wr(OFS_FLAGS, 32'h200);
      done("overheat");
      wr(OFS_CTRL, 32'h2003);
      en_pin <= 1'b0;
      w(360);
      ck("en early", reg_run, 4'h3);
      w(40);
      ck("en pin", reg_run, 4'h1);
      en_pin <= 1'b1;
      done("enable pin");
      wr(OFS_GPO, 32'h1);
      w(2);
      ck("od low", {g1o, g1oe}, 2'b01);
      wr(OFS_GPO, 32'h5);
      wr(OFS_CTRL, 32'h211);
      w(2);
      ck("od high", g1oe, 0);
      ck("pin sel", {pin_sel, g2oe}, 2'b10);
      wr(OFS_CTRL, 32'h411);
      w(3);
      rc("ctrl dflt", OFS_CTRL, 32'hffff, 32'h0);
      rc("rst flag", OFS_FLAGS, 32'h800, 32'h800);
      wr(OFS_FLAGS, 32'h800);
      wr(OFS_CTRL, 32'h1);
      w(5);
      sup_ok <= 1'b0;
      w(8);
      ck("uv run", {reg_run, dis_on}, 8'h0f);
      ov_cmp <= 1'b1;
      w(200);
      rc("ovp off", OFS_STATUS, 32'h400, 32'h0);
      ov_cmp <= 1'b0;
      sup_ok <= 1'b1;
      w(400);
      rc("uv state", OFS_STATUS, 32'h3000, 32'h1000);
      rc("uv flag", OFS_FLAGS, 32'h800, 32'h800);
      done("soft reset and undervoltage");
      print_verdict();
   end
endmodule
